/* hdl/config_access_router_map.vh */
// address map, field positions and reset values of the configuration access router
`ifndef CONFIG_ACCESS_ROUTER_MAP_VH
`define CONFIG_ACCESS_ROUTER_MAP_VH

// apb byte offsets
`define OFF_ADDR_PORT    12'h000
`define OFF_DATA_WINDOW  12'h004
`define OFF_REQ_CTRL     12'h008
`define OFF_STATUS       12'h00C
`define OFF_SEC_BUS_GFX  12'h010
`define OFF_SUB_BUS_GFX  12'h014
`define OFF_SEC_BUS_HUBB 12'h018
`define OFF_SUB_BUS_HUBB 12'h01C
`define OFF_DEV0_SCRATCH 12'h020
`define OFF_STRAP        12'h024

// config_address_port fields
`define CA_ENABLE_BIT    31
`define CA_BUS_HI        23
`define CA_BUS_LO        16
`define CA_DEV_HI        15
`define CA_DEV_LO        11
`define CA_FN_HI         10
`define CA_FN_LO         8
`define CA_REG_HI        7
`define CA_REG_LO        2
`define CA_WRITE_MASK    32'h80FFFFFC

// request control: bits 1:0 access size, bit 2 target addr(0)/data(1), bit 3 write
`define RC_SIZE_HI       1
`define RC_SIZE_LO       0
`define RC_SEL_DATA      2
`define RC_WRITE         3
`define SIZE_BYTE        2'h0
`define SIZE_WORD        2'h1
`define SIZE_DWORD       2'h2

// routing destination codes
`define DEST_NONE        3'h0
`define DEST_INTERNAL    3'h1
`define DEST_HUBA        3'h2
`define DEST_GFX         3'h3
`define DEST_HUBB        3'h4
`define DEST_HUBA_IO     3'h5

// device numbers on bus zero
`define DEV_HOST_HUBA    5'h00
`define DEV_GFX_BRIDGE   5'h01
`define DEV_HUBB_BRIDGE  5'h02
`define BUS_ZERO         8'h00
`define GFX_PRIMARY_BUS  8'h00

// attribute bits in dev0 scratch: 7:0 rw, 8 w1c, 9 write once, 10 lock, 11 lockable
`define SCR_RW_HI        7
`define SCR_W1C          8
`define SCR_WONCE        9
`define SCR_LOCK         10
`define SCR_LOCKABLE     11
`define SCR_RESET        12'h000
`define STRB_DWORD       4'hF
`define GFX_SEC_HI       15
`define GFX_SEC_LO       8
`define STRAP_SETTLED    2'h3
`define RESERVED_READ    32'h00000000

`endif

/* hdl/bus_route_decode.v */
// routing decoder from stored configuration address to destination and cycle type
`timescale 1ns/100ps
`include "config_access_router_map.vh"
module bus_route_decode (
  input  wire [31:0] address,
  input  wire [7:0]  gfx_secondary,
  input  wire [7:0]  gfx_subordinate,
  input  wire [7:0]  hubb_secondary,
  input  wire [7:0]  hubb_subordinate,
  output reg  [2:0]  dest,
  output reg         type1
);

  // true when bus lies strictly above secondary and at or below subordinate
  function in_range;
    input [7:0] bus;
    input [7:0] sec;
    input [7:0] sub;
    begin
      in_range = (bus > sec) && (bus <= sub);
    end
  endfunction

  wire [7:0] bus = address[`CA_BUS_HI:`CA_BUS_LO];
  wire [4:0] dev = address[`CA_DEV_HI:`CA_DEV_LO];

  // bus and device decode, internal devices win on bus zero
  always @* begin
    dest  = `DEST_HUBA;
    type1 = 1'b0;
    if (bus == `BUS_ZERO) begin
      if (dev == `DEV_HOST_HUBA || dev == `DEV_GFX_BRIDGE ||
          dev == `DEV_HUBB_BRIDGE)
        dest = `DEST_INTERNAL;
      else
        dest = `DEST_HUBA;
    end else if (bus == gfx_secondary) begin
      dest = `DEST_GFX;
    end else if (in_range(bus, gfx_secondary, gfx_subordinate)) begin
      dest  = `DEST_GFX;
      type1 = 1'b1;
    end else if (bus == hubb_secondary) begin
      dest = `DEST_HUBB;
    end else if (in_range(bus, hubb_secondary, hubb_subordinate)) begin
      dest  = `DEST_HUBB;
      type1 = 1'b1;
    end else begin
      dest  = `DEST_HUBA;
      type1 = 1'b1;
    end
  end

endmodule

/* hdl/strap_capture.v */
// captures strap levels once at release of reset
`timescale 1ns/100ps
`include "config_access_router_map.vh"
module strap_capture #(
  parameter WIDTH = 2
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] strap_pins,
  output reg  [WIDTH-1:0] strap_value
);

  reg [WIDTH-1:0] sync_a;
  reg [WIDTH-1:0] sync_b;
  reg [1:0]       age;
  reg             taken;

  // two-stage synchroniser; sync_b holds pin levels only from the second edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a      <= {WIDTH{1'b0}};
      sync_b      <= {WIDTH{1'b0}};
      strap_value <= {WIDTH{1'b0}};
      age         <= 2'h0;
      taken       <= 1'b0;
    end else begin
      sync_a <= strap_pins;
      sync_b <= sync_a;
      age    <= {age[0], 1'b1};
      // one-shot capture; pins must be settled before reset release
      if (age == `STRAP_SETTLED && !taken) begin
        strap_value <= sync_b;
        taken       <= 1'b1;
      end
    end
  end

endmodule

/* hdl/config_access_router.v */
// configuration access router: address port, data window and cycle routing
`timescale 1ns/100ps
`include "config_access_router_map.vh"
module config_access_router #(
  parameter STRAP_WIDTH = 2
) (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   partial_resetn,
  input  wire [STRAP_WIDTH-1:0] strap_pins,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output wire                   pready,
  output reg  [31:0]            prdata,
  output wire                   pslverr,
  output reg                    cycle_valid,
  output reg  [2:0]             cycle_dest,
  output reg                    cycle_type1,
  output reg                    cycle_write,
  output reg  [31:0]            cycle_address,
  output reg  [31:0]            cycle_data,
  output reg  [3:0]             cycle_byte_en
);

  // stored state
  reg  [31:0] config_address_port;
  reg  [31:0] config_data_window;
  reg  [3:0]  req_ctrl;
  reg  [7:0]  gfx_secondary;
  reg  [7:0]  gfx_subordinate;
  reg  [7:0]  hubb_secondary;
  reg  [7:0]  hubb_subordinate;
  reg  [7:0]  dev0_rw;
  reg         write_one_to_clear;
  reg         write_once;
  reg         write_once_used;
  reg         lock_bit;
  reg         lockable;
  reg         part_sync_a;
  reg         part_sync_b;
  reg  [7:0]  last_dest_count;
  reg  [31:0] next_rdata;
  wire [2:0]  route_dest;
  wire        route_type1;
  wire [STRAP_WIDTH-1:0] strap_value;

  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire [1:0] req_size = req_ctrl[`RC_SIZE_HI:`RC_SIZE_LO];
  wire config_cycle_enable = config_address_port[`CA_ENABLE_BIT];
  wire go_addr  = wr && paddr == `OFF_REQ_CTRL && !pwdata[`RC_SEL_DATA];
  wire go_data  = wr && paddr == `OFF_REQ_CTRL && pwdata[`RC_SEL_DATA];
  // write that reaches the attribute lane of the scratch register
  wire scr_hi_wr = wr && paddr == `OFF_DEV0_SCRATCH && pstrb[1];

  // merge write data into an old word under byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  // convert an access size into byte enables (little endian, lowest lane first)
  function [3:0] size_lanes;
    input [1:0] size;
    begin
      case (size)
        `SIZE_BYTE: size_lanes = 4'h1;
        `SIZE_WORD: size_lanes = 4'h3;
        default:    size_lanes = 4'hF;
      endcase
    end
  endfunction

  // single-cycle apb access: no wait states, never an error
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  bus_route_decode u_decode (
    .address          (config_address_port),
    .gfx_secondary    (gfx_secondary),
    .gfx_subordinate  (gfx_subordinate),
    .hubb_secondary   (hubb_secondary),
    .hubb_subordinate (hubb_subordinate),
    .dest             (route_dest),
    .type1            (route_type1)
  );

  strap_capture #(
    .WIDTH (STRAP_WIDTH)
  ) u_strap (
    .pclk        (pclk),
    .presetn     (presetn),
    .strap_pins  (strap_pins),
    .strap_value (strap_value)
  );

  // partial reset comes from a pin: two flops before any logic reads it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_sync_a <= 1'b1;
      part_sync_b <= 1'b1;
    end else begin
      part_sync_a <= partial_resetn;
      part_sync_b <= part_sync_a;
    end
  end

  // host port registers, cleared by both full and partial reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_address_port <= 32'h00000000;
      config_data_window  <= 32'h00000000;
      req_ctrl            <= 4'h0;
    end else if (!part_sync_b) begin
      config_address_port <= 32'h00000000;
      config_data_window  <= 32'h00000000;
      req_ctrl            <= 4'h0;
    end else if (wr) begin
      // only a whole dword lands in the address port; narrow ones never update it
      if (paddr == `OFF_ADDR_PORT && pstrb == `STRB_DWORD)
        config_address_port <= pwdata & `CA_WRITE_MASK;
      // the window merges lanes, so byte and word writes keep the other bytes
      if (paddr == `OFF_DATA_WINDOW)
        config_data_window <= merge(config_data_window, pwdata, pstrb);
      if (paddr == `OFF_REQ_CTRL)
        req_ctrl <= pwdata[3:0];
    end
  end

  // bridge bus numbers, cleared by both full and partial reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gfx_secondary    <= 8'h00;
      gfx_subordinate  <= 8'h00;
      hubb_secondary   <= 8'h00;
      hubb_subordinate <= 8'h00;
    end else if (!part_sync_b) begin
      gfx_secondary    <= 8'h00;
      gfx_subordinate  <= 8'h00;
      hubb_secondary   <= 8'h00;
      hubb_subordinate <= 8'h00;
    end else if (wr) begin
      // graphics secondary sits in lane 1; lane 0 is the fixed primary number
      if (paddr == `OFF_SEC_BUS_GFX && pstrb[1])
        gfx_secondary <= pwdata[`GFX_SEC_HI:`GFX_SEC_LO];
      if (paddr == `OFF_SUB_BUS_GFX && pstrb[0])
        gfx_subordinate <= pwdata[7:0];
      if (paddr == `OFF_SEC_BUS_HUBB && pstrb[0])
        hubb_secondary <= pwdata[7:0];
      if (paddr == `OFF_SUB_BUS_HUBB && pstrb[0])
        hubb_subordinate <= pwdata[7:0];
    end
  end

  // scratch attribute bits, cleared by both full and partial reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_one_to_clear <= 1'b0;
      lock_bit           <= 1'b0;
      lockable           <= 1'b0;
    end else if (!part_sync_b) begin
      write_one_to_clear <= 1'b0;
      lock_bit           <= 1'b0;
      lockable           <= 1'b0;
    end else begin
      // lock is sticky until reset, so a locked field cannot be reopened
      if (scr_hi_wr) begin
        if (!lock_bit)
          lockable <= pwdata[`SCR_LOCKABLE];
        lock_bit <= lock_bit | pwdata[`SCR_LOCK];
      end
      // write one clears; hardware set wins when a cycle is sent in the same clock
      if (scr_hi_wr && pwdata[`SCR_W1C])
        write_one_to_clear <= 1'b0;
      if (go_data && config_cycle_enable)
        write_one_to_clear <= 1'b1;
    end
  end

  // memory-configuration bits survive partial reset, cleared by full reset only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev0_rw         <= 8'h00;
      write_once      <= 1'b0;
      write_once_used <= 1'b0;
    end else if (wr && paddr == `OFF_DEV0_SCRATCH) begin
      if (pstrb[0])
        dev0_rw <= pwdata[`SCR_RW_HI:0];
      if (pstrb[1] && !write_once_used) begin
        write_once      <= pwdata[`SCR_WONCE];
        write_once_used <= 1'b1;
      end
    end
  end

  // cycle launch: address port, data window or pass-through i/o
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_valid     <= 1'b0;
      cycle_dest      <= `DEST_NONE;
      cycle_type1     <= 1'b0;
      cycle_write     <= 1'b0;
      cycle_address   <= 32'h00000000;
      cycle_data      <= 32'h00000000;
      cycle_byte_en   <= 4'h0;
      last_dest_count <= 8'h00;
    end else begin
      cycle_valid <= 1'b0;
      if (go_addr && pwdata[`RC_SIZE_HI:`RC_SIZE_LO] != `SIZE_DWORD) begin
        cycle_valid   <= 1'b1;
        cycle_dest    <= `DEST_HUBA_IO;
        cycle_type1   <= 1'b0;
        cycle_write   <= pwdata[`RC_WRITE];
        cycle_address <= config_address_port;
        cycle_data    <= config_data_window;
        cycle_byte_en <= size_lanes(pwdata[`RC_SIZE_HI:`RC_SIZE_LO]);
      end else if (go_data) begin
        cycle_valid   <= 1'b1;
        cycle_write   <= pwdata[`RC_WRITE];
        cycle_address <= config_address_port;
        cycle_data    <= config_data_window;
        cycle_byte_en <= size_lanes(pwdata[`RC_SIZE_HI:`RC_SIZE_LO]);
        if (config_cycle_enable) begin
          cycle_dest  <= route_dest;
          cycle_type1 <= route_type1;
          last_dest_count <= last_dest_count + 8'h01;
        end else begin
          cycle_dest  <= `DEST_HUBA_IO;
          cycle_type1 <= 1'b0;
        end
      end
    end
  end

  // read mux, unmapped and reserved locations read as zero
  always @* begin
    next_rdata = `RESERVED_READ;
    case (paddr)
      `OFF_ADDR_PORT:    next_rdata = config_address_port;
      `OFF_DATA_WINDOW:  next_rdata = config_data_window;
      `OFF_REQ_CTRL:     next_rdata = {28'h0000000, req_ctrl};
      `OFF_STATUS:       next_rdata = {16'h0000, last_dest_count, 4'h0, route_type1,
                                       route_dest};
      `OFF_SEC_BUS_GFX:  next_rdata = {16'h0000, gfx_secondary, `GFX_PRIMARY_BUS};
      `OFF_SUB_BUS_GFX:  next_rdata = {24'h000000, gfx_subordinate};
      `OFF_SEC_BUS_HUBB: next_rdata = {24'h000000, hubb_secondary};
      `OFF_SUB_BUS_HUBB: next_rdata = {24'h000000, hubb_subordinate};
      `OFF_DEV0_SCRATCH: next_rdata = {20'h00000, lockable, lock_bit, write_once,
                                       write_one_to_clear, dev0_rw};
      `OFF_STRAP:        next_rdata = {{(32-STRAP_WIDTH){1'b0}}, strap_value};
      default:           next_rdata = `RESERVED_READ;
    endcase
  end

  // read data registered at setup so it is valid throughout access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= next_rdata;
  end

endmodule

/* tb/config_access_router_assertions.sv */
// checker for launch pulses, routing codes and bus answers of the router
`timescale 1ns/100ps
`include "config_access_router_map.vh"
module config_access_router_assertions (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire        pslverr,
  input wire        cycle_valid,
  input wire [2:0]  cycle_dest,
  input wire        cycle_type1,
  input wire        cycle_write,
  input wire [3:0]  cycle_byte_en
);
  reg [31:0] addr_q;
  wire [7:0] bus_q = addr_q[23:16];
  wire [4:0] dev_q = addr_q[15:11];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadow of the address port, built from completed dword writes only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      addr_q <= 32'h00000000;
    else if (psel && penable && pwrite && paddr == `OFF_ADDR_PORT && pstrb == 4'hF)
      addr_q <= pwdata & `CA_WRITE_MASK;
  end

  sequence launch_req;
    psel && penable && pwrite && paddr == `OFF_REQ_CTRL;
  endsequence
  sequence pulse_once;
    cycle_valid ##1 !cycle_valid;
  endsequence

  chk_launch_pulse: assert property (
    launch_req ##0 (pwdata[2] || pwdata[1:0] != 2'h2) |=> pulse_once)
    else $error("launch request gave no single-cycle pulse");
  chk_dword_no_launch: assert property (
    launch_req ##0 (!pwdata[2] && pwdata[1:0] == 2'h2) |=> !cycle_valid)
    else $error("address-port dword request launched a cycle");
  chk_launch_cause: assert property (
    cycle_valid |-> $past(psel) && $past(penable) && $past(pwrite) &&
                    $past(paddr) == `OFF_REQ_CTRL)
    else $error("cycle launched without a request write");
  chk_bus_answer: assert property (pready && !pslverr)
    else $error("bus answer not ready or error");
  chk_internal_route: assert property (
    cycle_valid && $past(pwdata[2]) && addr_q[31] && bus_q == 8'h00 && dev_q <= 5'h02
    |-> cycle_dest == `DEST_INTERNAL && !cycle_type1)
    else $error("internal device cycle left the block");
  chk_bus0_huba: assert property (
    cycle_valid && $past(pwdata[2]) && addr_q[31] && bus_q == 8'h00 && dev_q > 5'h02
    |-> cycle_dest == `DEST_HUBA && !cycle_type1)
    else $error("bus zero device above two not sent to hub A");
  chk_nonzero_type1: assert property (
    cycle_valid && cycle_dest == `DEST_HUBA && bus_q != 8'h00 |-> cycle_type1)
    else $error("nonzero bus on hub A not type 1");
  chk_enable_off: assert property (
    cycle_valid && $past(pwdata[2]) && !addr_q[31] |-> cycle_dest == `DEST_HUBA_IO)
    else $error("disabled window access made a config cycle");
  chk_narrow_io: assert property (
    cycle_valid && !$past(pwdata[2]) |-> cycle_dest == `DEST_HUBA_IO)
    else $error("narrow address-port access not plain I/O");
  chk_byte_en: assert property (
    cycle_valid |-> cycle_byte_en == ($past(pwdata[1:0]) == 2'h0 ? 4'h1 :
                                      $past(pwdata[1:0]) == 2'h1 ? 4'h3 : 4'hF))
    else $error("byte enables do not match access size");
  chk_write_dir: assert property (cycle_valid |-> cycle_write == $past(pwdata[3]))
    else $error("cycle direction differs from request");
endmodule

bind config_access_router config_access_router_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .cycle_valid(cycle_valid), .cycle_dest(cycle_dest), .cycle_type1(cycle_type1),
  .cycle_write(cycle_write), .cycle_byte_en(cycle_byte_en)
);

/* tb/host_cfg_model.sv */
// host model: bus master issuing address-port and data-window accesses
`timescale 1ns/100ps
module host_cfg_model (
  input  wire        pclk,
  input  wire        pready,
  input  wire [31:0] prdata,
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hFFF;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end

  // setup then access, held until pready; released lines show the inverse
  task xfer(input w, input [11:0] a, input [31:0] d, input [3:0] s, output [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? s : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task wr(input [11:0] a, input [31:0] d, input [3:0] s);
    logic [31:0] r;
    xfer(1'b1, a, d, s, r);
  endtask

  task rd(input [11:0] a, output [31:0] r);
    xfer(1'b0, a, 32'h00000000, 4'h0, r);
  endtask

  // reserved bits kept by read, merge, write
  task rmw(input [11:0] a, input [31:0] m, input [31:0] d);
    logic [31:0] r;
    rd(a, r);
    wr(a, (r & ~m) | (d & m), 4'hF);
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench: register attributes, resets, straps and cycle routing
`timescale 1ns/100ps
`include "config_access_router_map.vh"
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        partial_resetn = 1'b1;
  logic [1:0]  strap_pins = 2'h2;
  wire         psel, penable, pwrite, pready, pslverr, cycle_valid, cycle_type1, cycle_write;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata, cycle_address, cycle_data;
  wire  [3:0]  pstrb, cycle_byte_en;
  wire  [2:0]  cycle_dest;
  int          err_count = 0;
  int          n_compared = 0;
  logic [31:0] v;

  always #4 pclk = ~pclk;

  config_access_router #(.STRAP_WIDTH(2)) i_dut (
    .pclk(pclk), .presetn(presetn), .partial_resetn(partial_resetn), .strap_pins(strap_pins),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cycle_valid(cycle_valid), .cycle_dest(cycle_dest), .cycle_type1(cycle_type1),
    .cycle_write(cycle_write), .cycle_address(cycle_address), .cycle_data(cycle_data),
    .cycle_byte_en(cycle_byte_en));

  host_cfg_model i_host (
    .pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task cmp(input string what, input [31:0] exp, input [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task rd_chk(input [11:0] a, input [31:0] exp);
    i_host.rd(a, v);
    cmp($sformatf("register %h", a), exp, v);
  endtask

  function [31:0] mk(input en, input [7:0] b, input [4:0] d);
    mk = {en, 7'h00, b, d, 3'h1, 6'h02, 2'h0};
  endfunction

  // r packs request control, expected dest, expected type1 and byte enables
  task launch(input [31:0] a, input [11:0] r);
    i_host.wr(`OFF_ADDR_PORT, a, 4'hF);
    i_host.wr(`OFF_DATA_WINDOW, ~a, 4'hF);
    i_host.wr(`OFF_REQ_CTRL, {28'h0, r[11:8]}, 4'hF);
    @(negedge pclk);
    cmp("valid", 32'h1, {31'h0, cycle_valid});
    cmp("dest", {29'h0, r[7:5]}, {29'h0, cycle_dest});
    cmp("type1", {31'h0, r[4]}, {31'h0, cycle_type1});
    cmp("byte_en", {28'h0, r[3:0]}, {28'h0, cycle_byte_en});
    cmp("write", {31'h0, r[11]}, {31'h0, cycle_write});
    cmp("address", a, cycle_address);
    cmp("data", ~a, cycle_data);
    @(negedge pclk);
    cmp("pulse end", 32'h0, {31'h0, cycle_valid});
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    wrap_up;
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(`OFF_STRAP, 32'h2);
    strap_pins <= 2'h1;
    rd_chk(`OFF_STRAP, 32'h2);
    rd_chk(12'h040, `RESERVED_READ);
    rd_chk(`OFF_STATUS, 32'h00000001);
    i_host.wr(`OFF_STATUS, 32'hFFFFFFFF, 4'hF);
    rd_chk(`OFF_STATUS, 32'h00000001);
    i_host.wr(`OFF_ADDR_PORT, 32'hFFFFFFFF, 4'hF);
    rd_chk(`OFF_ADDR_PORT, 32'h80FFFFFC);
    $display("test registers done");
    // scratch attributes, before any launch sets the clear-on-one bit
    i_host.wr(`OFF_DEV0_SCRATCH, 32'h000002A5, 4'hF);
    rd_chk(`OFF_DEV0_SCRATCH, 32'h000002A5);
    i_host.wr(`OFF_DEV0_SCRATCH, 32'h00000000, 4'hF);
    rd_chk(`OFF_DEV0_SCRATCH, 32'h00000200);
    i_host.wr(`OFF_DEV0_SCRATCH, 32'h00000E00, 4'hF);
    i_host.wr(`OFF_DEV0_SCRATCH, 32'h00000600, 4'hF);
    rd_chk(`OFF_DEV0_SCRATCH, 32'h00000E00);
    i_host.wr(`OFF_DEV0_SCRATCH, 32'hFFFFFE3C, 4'h1);
    rd_chk(`OFF_DEV0_SCRATCH, 32'h00000E3C);
    $display("test attributes done");
    // bridge windows: graphics 05..08, hub B 0A..0C
    i_host.rmw(`OFF_SEC_BUS_GFX, 32'h0000FFFF, 32'h00000505);
    rd_chk(`OFF_SEC_BUS_GFX, 32'h00000500);
    i_host.wr(`OFF_SUB_BUS_GFX, 32'h08080808, 4'hF);
    i_host.wr(`OFF_SEC_BUS_HUBB, 32'h0A0A0A0A, 4'hF);
    i_host.wr(`OFF_SUB_BUS_HUBB, 32'h0C0C0C0C, 4'hF);
    launch(mk(1'b1, 8'h00, 5'h00), 12'h62F);
    launch(mk(1'b1, 8'h00, 5'h02), 12'hE2F);
    launch(mk(1'b1, 8'h00, 5'h01), 12'h421);
    launch(mk(1'b1, 8'h00, 5'h03), 12'h64F);
    launch(mk(1'b1, 8'h00, 5'h1F), 12'h543);
    launch(mk(1'b1, 8'h05, 5'h00), 12'h66F);
    launch(mk(1'b1, 8'h06, 5'h00), 12'h67F);
    launch(mk(1'b1, 8'h08, 5'h04), 12'h67F);
    launch(mk(1'b1, 8'h09, 5'h00), 12'h65F);
    launch(mk(1'b1, 8'h04, 5'h00), 12'h65F);
    launch(mk(1'b1, 8'h0A, 5'h00), 12'h68F);
    launch(mk(1'b1, 8'h0C, 5'h00), 12'h69F);
    launch(mk(1'b1, 8'h0D, 5'h00), 12'h65F);
    launch(mk(1'b0, 8'h00, 5'h00), 12'h6AF);
    launch(mk(1'b1, 8'h00, 5'h00), 12'h0A1);
    launch(mk(1'b1, 8'h00, 5'h00), 12'h1A3);
    i_host.wr(`OFF_REQ_CTRL, 32'h00000002, 4'hF);
    @(negedge pclk);
    cmp("no launch", 32'h0, {31'h0, cycle_valid});
    $display("test routing done");
    rd_chk(`OFF_DEV0_SCRATCH, 32'h00000F3C);
    i_host.wr(`OFF_DEV0_SCRATCH, 32'h00000E3C, 4'hF);
    rd_chk(`OFF_DEV0_SCRATCH, 32'h00000F3C);
    i_host.wr(`OFF_DEV0_SCRATCH, 32'h00000F3C, 4'hF);
    rd_chk(`OFF_DEV0_SCRATCH, 32'h00000E3C);
    // partial reset keeps byte 0 and the write-once state
    @(posedge pclk);
    partial_resetn <= 1'b0;
    repeat (2) @(posedge pclk);
    partial_resetn <= 1'b1;
    // the pin passes a two-flop synchroniser before it acts
    repeat (4) @(posedge pclk);
    rd_chk(`OFF_DEV0_SCRATCH, 32'h0000023C);
    rd_chk(`OFF_SEC_BUS_GFX, 32'h00000000);
    i_host.wr(`OFF_DEV0_SCRATCH, 32'h00000000, 4'hF);
    rd_chk(`OFF_DEV0_SCRATCH, 32'h00000200);
    // full reset clears everything and samples the new strap level
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(`OFF_DEV0_SCRATCH, 32'h00000000);
    rd_chk(`OFF_STRAP, 32'h1);
    $display("test resets done");
    wrap_up;
  end
endmodule
